// file: efm_cfg.svh
// constants for the exact-frequency modulator control block
`ifndef EFM_CFG_SVH
`define EFM_CFG_SVH
`define EFM_REG_SOFT_RESET 5'h00
`define EFM_REG_INTEGER 5'h03
`define EFM_REG_FRACTIONAL 5'h04
`define EFM_REG_MOD_CONFIG 5'h06
`define EFM_REG_EXACT_DIV 5'h0C
`define EFM_SOFT_RESET_BIT 5
`define EFM_MOD_ENABLE_BIT 11
`define EFM_MOD_BYPASS_BIT 7
`define EFM_SEED_LSB 0
`define EFM_CHIP_ADDR 3'h0
`define EFM_FRAME_BITS 32
`define EFM_DATA_BITS 24
`define EFM_INTEGER_RST 24'h000019
`define EFM_FRACTIONAL_RST 24'h000000
`define EFM_MOD_CONFIG_RST 24'h000882
`define EFM_EXACT_DIV_RST 24'h000000
`define EFM_POR_TIME_US 250
`define EFM_CLK_MHZ 200
`define EFM_POR_CYCLES (`EFM_POR_TIME_US * `EFM_CLK_MHZ)
`define EFM_SEED_0 24'h000000
`define EFM_SEED_1 24'h800000
`define EFM_SEED_2 24'hB2D05E
`define EFM_SEED_3 24'h50F4B4
`endif

// file: efm_device.sv
// device end: serial register capture, reset and modulator core
`include "efm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - host loads integer with floor(fvco/fpd)
// - host loads exact divisor fpd/gcd
// - host loads fractional with ceiling formula
// - exact mode only when gcd >= fpd/2^14
// - channel change rewrites fractional register only
// - channel mode divisor uses channel spacing gcd
// - channel mode needs two adjacent valid channels
// - two-bit seed selects four start phases
// - new fractional word reloads seed into accumulator
// - host should pick seed code two
// - power-on reset restores defaults after 250us
// - write register zero bit5 soft-resets registers
// - soft reset keeps serial port mode
// - soft reset leaves oscillator registers alone
// - slow supply: soft reset is first write
// - fractional needs enable set, bypass clear
// - 32-bit msb-first frame captured on strobe rise
module efm_device #(
  parameter int POR_CYCLES = `EFM_POR_CYCLES
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  efm_link_if.device link,
  input wire logic pd_tick_i,
  input wire logic [23:0] osc_reg_i,
  output logic por_done_o,
  output logic [23:0] integer_o,
  output logic [23:0] fractional_o,
  output logic [23:0] exact_div_o,
  output logic [23:0] osc_reg_o,
  output logic spi_mode_o,
  output logic frac_mode_o,
  output logic [23:0] phase_o,
  output logic carry_o
);
  typedef struct packed {
    logic [2:0] clk_s;
    logic [2:0] strb_s;
    logic [1:0] data_s;
    logic [31:0] shift;
    logic [31:0] por_cnt;
    logic por_done;
    logic [23:0] integer_div;
    logic [23:0] fractional;
    logic [23:0] mod_config;
    logic [23:0] exact_div;
    logic [23:0] osc_reg;
    logic spi_mode;
    logic reload;
  } efm_dev_t;
  efm_dev_t st_reg;
  efm_dev_t st_next;
  logic clk_rise;
  logic strb_rise;
  logic [4:0] w_addr;
  logic [23:0] w_data;
  logic [23:0] seed;

  // ---------------------------------------------------------------
  // seed table
  // ---------------------------------------------------------------
  // fixed start phases; codes 2 and 3 are the non-binary choices
  always_comb begin
    case (st_reg.mod_config[`EFM_SEED_LSB +: 2])
      2'h0: seed = `EFM_SEED_0;
      2'h1: seed = `EFM_SEED_1;
      2'h2: seed = `EFM_SEED_2;
      default: seed = `EFM_SEED_3;
    endcase
  end

  // edges are only taken from the second and third stages
  assign clk_rise = st_reg.clk_s[1] & ~st_reg.clk_s[2];
  assign strb_rise = st_reg.strb_s[1] & ~st_reg.strb_s[2];
  assign w_data = st_reg.shift[31:8];
  assign w_addr = st_reg.shift[7:3];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.reload = 1'b0;
    st_next.clk_s = {st_reg.clk_s[1:0], link.serial_clk};
    st_next.strb_s = {st_reg.strb_s[1:0], link.serial_enable_strobe};
    st_next.data_s = {st_reg.data_s[0], link.serial_data_in};
    // shift msb first on serial clock rise
    if (clk_rise) begin
      st_next.shift = {st_reg.shift[30:0], st_reg.data_s[1]};
    end
    // power-on count; writes ignored until it expires
    if (!st_reg.por_done) begin
      if (st_reg.por_cnt >= 32'(POR_CYCLES - 1)) begin
        st_next.por_done = 1'b1;
        st_next.osc_reg = osc_reg_i; // caught at release
      end else begin
        st_next.por_cnt = st_reg.por_cnt + 32'h00000001;
      end
    end else if (strb_rise && st_reg.shift[2:0] == `EFM_CHIP_ADDR) begin
      // word captured on strobe rise
      if (w_addr == `EFM_REG_SOFT_RESET) begin
        if (w_data[`EFM_SOFT_RESET_BIT]) begin
          // spi_mode and osc_reg kept
          st_next.integer_div = `EFM_INTEGER_RST;
          st_next.fractional = `EFM_FRACTIONAL_RST;
          st_next.mod_config = `EFM_MOD_CONFIG_RST;
          st_next.exact_div = `EFM_EXACT_DIV_RST;
          st_next.reload = 1'b1;
        end
      end else if (w_addr == `EFM_REG_INTEGER) begin
        st_next.integer_div = w_data;
      end else if (w_addr == `EFM_REG_FRACTIONAL) begin
        st_next.fractional = w_data; // channel change
        st_next.reload = 1'b1;
      end else if (w_addr == `EFM_REG_MOD_CONFIG) begin
        st_next.mod_config = w_data;
      end else if (w_addr == `EFM_REG_EXACT_DIV) begin
        st_next.exact_div = w_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // sys_rst_i stands for the supply-level reset: it clears the oscillator
  // shadow, loads integer and mod_config defaults and sets serial mode
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
      st_reg.integer_div <= `EFM_INTEGER_RST;
      st_reg.mod_config <= `EFM_MOD_CONFIG_RST;
      st_reg.spi_mode <= 1'b1;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  efm_phase_acc u_acc (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .step_i(pd_tick_i & frac_mode_o),
    .reload_i(st_reg.reload),
    .seed_i(seed),
    .frac_i(st_reg.fractional),
    .exact_div_i(st_reg.exact_div),
    .phase_o(phase_o),
    .carry_o(carry_o)
  );

  // fractional only with enable set and bypass clear
  assign frac_mode_o = st_reg.mod_config[`EFM_MOD_ENABLE_BIT] &
                       ~st_reg.mod_config[`EFM_MOD_BYPASS_BIT];
  assign por_done_o = st_reg.por_done;
  assign integer_o = st_reg.integer_div;
  assign fractional_o = st_reg.fractional;
  assign exact_div_o = st_reg.exact_div;
  assign osc_reg_o = st_reg.osc_reg;
  assign spi_mode_o = st_reg.spi_mode;
endmodule
`default_nettype wire

// file: efm_host.sv
// host end: turns one register write request into a serial frame
`include "efm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module efm_host #(
  parameter int HALF_CYCLES = 2
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  efm_link_if.host link,
  input wire logic wr_valid_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [23:0] wr_data_i,
  output logic wr_ready_o,
  output logic done_o
);
  typedef struct packed {
    efm_pkg::efm_host_state_t state;
    logic [31:0] shift;
    logic [5:0] bits;
    logic [7:0] div;
    logic sclk;
    logic strobe;
    logic done;
  } efm_host_st_t;
  efm_host_st_t st_reg;
  efm_host_st_t st_next;

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------
  // data changes on falling serial clock, device samples on rise;
  // host software keeps to
  // when choosing what to write
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      efm_pkg::EFM_H_IDLE: begin
        if (wr_valid_i) begin
          st_next.shift = {wr_data_i, wr_addr_i, `EFM_CHIP_ADDR};
          st_next.bits = 6'h00;
          st_next.div = 8'h00;
          st_next.state = efm_pkg::EFM_H_SHIFT;
        end
      end
      efm_pkg::EFM_H_SHIFT: begin
        st_next.div = st_reg.div + 8'h01;
        if (st_reg.div == 8'(HALF_CYCLES - 1)) begin
          st_next.div = 8'h00;
          st_next.sclk = ~st_reg.sclk;
          if (st_reg.sclk) begin
            st_next.shift = {st_reg.shift[30:0], 1'b0};
            st_next.bits = st_reg.bits + 6'h01;
            if (st_reg.bits == 6'(`EFM_FRAME_BITS - 1)) begin
              st_next.state = efm_pkg::EFM_H_STROBE;
            end
          end
        end
      end
      efm_pkg::EFM_H_STROBE: begin
        st_next.div = st_reg.div + 8'h01;
        st_next.strobe = 1'b1; // rising strobe commits
        if (st_reg.div == 8'(2 * HALF_CYCLES)) begin
          st_next.strobe = 1'b0;
          st_next.done = 1'b1;
          st_next.state = efm_pkg::EFM_H_IDLE;
        end
      end
      default: st_next.state = efm_pkg::EFM_H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
      st_reg.state <= efm_pkg::EFM_H_IDLE;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign wr_ready_o = st_reg.state == efm_pkg::EFM_H_IDLE;
  assign done_o = st_reg.done;
  assign link.serial_clk = st_reg.sclk;
  assign link.serial_data_in = st_reg.shift[31];
  assign link.serial_enable_strobe = st_reg.strobe;
endmodule
`default_nettype wire

// file: efm_link_if.sv
// serial write link between the host controller and the device
`timescale 1ns/1ps
`default_nettype none
interface efm_link_if;
  logic serial_clk;
  logic serial_data_in;
  logic serial_enable_strobe;
  modport host (
    output serial_clk,
    output serial_data_in,
    output serial_enable_strobe
  );
  modport device (
    input serial_clk,
    input serial_data_in,
    input serial_enable_strobe
  );
endinterface
`default_nettype wire

// file: efm_link_monitor.sv
// concurrent checks on the serial write link between host and device
`timescale 1ns/1ps
`default_nettype none
module efm_link_monitor (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic serial_enable_strobe
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // rising serial clocks since the last strobe
  // ----------------------------------------
  logic sclk_reg;
  logic [5:0] rises_reg;
  always_ff @(posedge mclk_i) begin
    sclk_reg <= serial_clk;
    if (sys_rst_i || serial_enable_strobe) begin
      rises_reg <= 6'h00;
    end else if (serial_clk && !sclk_reg) begin
      rises_reg <= rises_reg + 6'h01;
    end
  end
  property p_frame_len;
    $rose(serial_enable_strobe) |-> rises_reg == 6'h20;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("strobe rose without 32 clock bits");
  property p_quiet_strobe;
    serial_enable_strobe |-> !serial_clk;
  endproperty
  a_quiet_strobe: assert property (p_quiet_strobe)
    else $error("serial clock high during strobe");
  property p_strobe_len;
    $rose(serial_enable_strobe) |-> serial_enable_strobe[*4] ##1
      !serial_enable_strobe;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe width wrong");
  property p_clk_high;
    $rose(serial_clk) |-> serial_clk[*2] ##1 !serial_clk;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("serial clock high phase wrong");
  property p_clk_low;
    $fell(serial_clk) && rises_reg < 6'h20 |-> !serial_clk[*2] ##1 serial_clk;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("serial clock low phase wrong");
  property p_data_hold;
    serial_clk |-> $stable(serial_data_in);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved while serial clock high");
  property p_strobe_soon;
    $fell(serial_clk) && rises_reg == 6'h20 |-> ##[1:8] serial_enable_strobe;
  endproperty
  a_strobe_soon: assert property (p_strobe_soon)
    else $error("strobe late after last bit");
  property p_frame_time;
    $rose(serial_clk) && rises_reg == 6'h00 |->
      ##[64:200] $rose(serial_enable_strobe);
  endproperty
  a_frame_time: assert property (p_frame_time)
    else $error("frame did not close in time");
endmodule
`default_nettype wire

// file: efm_phase_acc.sv
// fractional phase accumulator with seed reload and exact-step wrap
`timescale 1ns/1ps
`default_nettype none
module efm_phase_acc (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic step_i,
  input wire logic reload_i,
  input wire logic [23:0] seed_i,
  input wire logic [23:0] frac_i,
  input wire logic [23:0] exact_div_i,
  output logic [23:0] phase_o,
  output logic carry_o
);
  typedef struct packed {
    logic [23:0] acc;
    logic [23:0] step_cnt;
    logic carry;
  } efm_acc_t;
  efm_acc_t st_reg;
  efm_acc_t st_next;
  logic [24:0] sum;

  // ---------------------------------------------------------------
  // accumulate
  // ---------------------------------------------------------------
  // the accumulator restarts from the seed phase after exact_div
  // steps so the pattern repeats on the exact channel plan
  always_comb begin
    st_next = st_reg;
    sum = {1'b0, st_reg.acc} + {1'b0, frac_i};
    st_next.carry = 1'b0;
    if (reload_i) begin
      st_next.acc = seed_i;
      st_next.step_cnt = 24'h000000;
    end else if (step_i) begin
      st_next.acc = sum[23:0]; // modulo 2^24
      st_next.carry = sum[24];
      st_next.step_cnt = st_reg.step_cnt + 24'h000001;
      if (exact_div_i != 24'h000000 &&
          st_reg.step_cnt + 24'h000001 >= exact_div_i) begin
        st_next.acc = seed_i;
        st_next.step_cnt = 24'h000000;
      end
    end
  end

  // register state; clock enable freezes everything
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign phase_o = st_reg.acc;
  assign carry_o = st_reg.carry;
endmodule
`default_nettype wire

// file: efm_pkg.sv
// shared types for the exact-frequency modulator control block
package efm_pkg;
  typedef enum logic [2:0] {
    EFM_H_IDLE = 3'b001,
    EFM_H_SHIFT = 3'b010,
    EFM_H_STROBE = 3'b100
  } efm_host_state_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [23:0] data;
  } efm_word_t;
endpackage

// file: exact_frequency_modulator_control_tb.sv
// self-checking bench: host and device joined over the serial link
`include "efm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module exact_frequency_modulator_control_tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_valid = 1'b0;
  logic [4:0] wr_addr = 5'h00;
  logic [23:0] wr_data = 24'h000000;
  logic [23:0] osc_in = 24'h00A5C3;
  logic pd_tick = 1'b0;
  logic wr_ready, done, por_done, spi_mode, frac_mode;
  logic [23:0] int_q, frac_q, exact_q, osc_q, phase;
  logic [31:0] frame_sh = 32'h0;
  logic [31:0] frame_cap = 32'h0;
  logic [23:0] seeds [4] = '{`EFM_SEED_0, `EFM_SEED_1, `EFM_SEED_2,
    `EFM_SEED_3};
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int carries = 0;
  logic carry;
  efm_link_if link ();
  efm_host #(.HALF_CYCLES(2)) efm_host_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .link(link),
    .wr_valid_i(wr_valid), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .wr_ready_o(wr_ready), .done_o(done));
  efm_device #(.POR_CYCLES(20)) efm_device_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .link(link),
    .pd_tick_i(pd_tick), .osc_reg_i(osc_in), .por_done_o(por_done),
    .integer_o(int_q), .fractional_o(frac_q), .exact_div_o(exact_q),
    .osc_reg_o(osc_q), .spi_mode_o(spi_mode), .frac_mode_o(frac_mode),
    .phase_o(phase), .carry_o(carry));
  efm_link_monitor efm_link_monitor_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .serial_clk(link.serial_clk),
    .serial_data_in(link.serial_data_in),
    .serial_enable_strobe(link.serial_enable_strobe));
  always #2.5 mclk_i = ~mclk_i;
  // wire-side copy of the frame, so the bit order is judged independently
  always @(posedge link.serial_clk) frame_sh <= {frame_sh[30:0],
    link.serial_data_in};
  always @(posedge link.serial_enable_strobe) frame_cap = frame_sh;
  // carry stands one cycle only, so each pulse is counted as it passes
  always @(posedge mclk_i) begin
    if (carry === 1'b1) begin
      carries++;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask
  // one register write; waits for the frame end and the device update
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    int n = 0;
    @(posedge mclk_i);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge mclk_i);
    wr_valid <= 1'b0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (4) @(posedge mclk_i);
    #1;
    chk("frame", {d, a, 3'h0}, frame_cap);
  endtask
  task automatic tick();
    @(posedge mclk_i);
    pd_tick <= 1'b1;
    @(posedge mclk_i);
    pd_tick <= 1'b0;
    @(posedge mclk_i);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_por();
    int n = 0;
    chk("integer", `EFM_INTEGER_RST, int_q);
    chk("fractional", `EFM_FRACTIONAL_RST, frac_q);
    chk("exact", `EFM_EXACT_DIV_RST, exact_q);
    chk("por_done", 1'b0, por_done);
    while (por_done !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
    chk("por_late", 1'b1, por_done);
    chk("por_early", 1'b1, n >= 15);
    chk("osc", 24'h00A5C3, osc_q);
    wr(`EFM_REG_SOFT_RESET, 24'h000020);
    chk("first_write", `EFM_INTEGER_RST, int_q);
    $display("test por done");
  endtask
  task automatic t_exact();
    wr(`EFM_REG_INTEGER, 24'h00002D);
    wr(`EFM_REG_EXACT_DIV, 24'h000C00);
    wr(`EFM_REG_FRACTIONAL, 24'h938000);
    wr(`EFM_REG_MOD_CONFIG, 24'h000802);
    chk("integer", 24'h00002D, int_q);
    chk("exact", 24'h000C00, exact_q);
    chk("fractional", 24'h938000, frac_q);
    chk("frac_mode", 1'b1, frac_mode);
    wr(`EFM_REG_FRACTIONAL, 24'h93EAAB);
    chk("channel", 24'h93EAAB, frac_q);
    chk("integer_kept", 24'h00002D, int_q);
    chk("exact_kept", 24'h000C00, exact_q);
    wr(`EFM_REG_MOD_CONFIG, 24'h000882);
    chk("frac_mode", 1'b0, frac_mode);
    $display("test exact done");
  endtask
  task automatic t_soft();
    // move the accumulator off the seed so the reload is visible
    wr(`EFM_REG_MOD_CONFIG, 24'h000802);
    tick();
    chk("moved", 24'(`EFM_SEED_2 + 24'h93EAAB), phase);
    osc_in <= 24'h005A3C;
    wr(`EFM_REG_SOFT_RESET, 24'h000020);
    chk("integer", `EFM_INTEGER_RST, int_q);
    chk("fractional", `EFM_FRACTIONAL_RST, frac_q);
    chk("exact", `EFM_EXACT_DIV_RST, exact_q);
    chk("spi_mode", 1'b1, spi_mode);
    chk("osc", 24'h00A5C3, osc_q);
    chk("phase", `EFM_SEED_2, phase);
    $display("test soft done");
  endtask
  // each seed code, then one step of the accumulator from it
  task automatic t_seed();
    int c0;
    logic [24:0] s;
    for (int k = 0; k < 4; k++) begin
      wr(`EFM_REG_MOD_CONFIG, 24'h000800 | 24'(k));
      wr(`EFM_REG_FRACTIONAL, 24'hC00003);
      chk("seed", seeds[k], phase);
      c0 = carries;
      s = {1'b0, seeds[k]} + 25'h0C00003;
      tick();
      chk("step", s[23:0], phase);
      chk("carry", s[24], carries - c0);
    end
    // exact divisor of two: every second step restarts from the seed
    wr(`EFM_REG_EXACT_DIV, 24'h000002);
    wr(`EFM_REG_FRACTIONAL, 24'h100000);
    tick();
    chk("wrap_1", 24'(`EFM_SEED_3 + 24'h100000), phase);
    tick();
    chk("wrap_2", `EFM_SEED_3, phase);
    $display("test seed done");
  endtask
  task finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard: the whole run needs only a few thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    t_por();
    t_exact();
    t_soft();
    t_seed();
    finish_test();
  end
endmodule
`default_nettype wire
